// ### spalm_alarm.sv
`timescale 1ns/1ns
`include "spalm_map.svh"
module spalm_alarm #(
    parameter int W = 24
) (
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    input  wire logic                sample,
    input  wire logic signed [W-1:0] reading,
    input  wire logic signed [W-1:0] level,
    input  wire logic signed [W-1:0] deadband,
    input  wire logic [6:0]          delay,
    input  wire logic                below,
    input  wire logic                latch_en,
    input  wire logic                disable_all,
    input  wire logic                clear,
    output logic                     active
);
    logic [6:0] cnt_r, cnt_nxt;
    logic       act_r, act_nxt;
    logic       beyond, released;
    assign active = act_r;

    // Trip at level, release past the full deadband on inactive side
    always_comb begin
        beyond   = below ? (reading < level) : (reading > level);
        released = below ? (reading > level + deadband)
                         : (reading < level - deadband);
        cnt_nxt  = cnt_r;
        act_nxt  = act_r;
        if (sample) begin
            if (!beyond) begin
                cnt_nxt = 7'h00;
            end else if (cnt_r < delay) begin
                cnt_nxt = cnt_r + 7'h01;
            end
            if (beyond && cnt_r >= delay) begin
                act_nxt = 1'b1;
            end else if (released && !latch_en) begin
                act_nxt = 1'b0;
            end
        end
        // Latched alarm only drops on a clear or disable_all; a live trip beats the clear
        if (clear && latch_en && !(sample && beyond && cnt_r >= delay)) begin
            act_nxt = 1'b0;
        end
        if (disable_all) begin
            act_nxt = 1'b0;
            cnt_nxt = 7'h00;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 7'h00;
            act_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            act_r <= act_nxt;
        end
    end
endmodule

// ### spalm_map.svh
`ifndef SPALM_MAP_SVH
`define SPALM_MAP_SVH
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SPALM_CLK_HZ        125000000
`define SPALM_CYCLE_SEC     15
`define SPALM_CYCLE_CLKS    (`SPALM_CYCLE_SEC * `SPALM_CLK_HZ)
`define SPALM_MSG_CLKS      1000
// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define SPALM_OFS_CTRL      8'h00
`define SPALM_OFS_SP1       8'h04
`define SPALM_OFS_SP2       8'h08
`define SPALM_OFS_SP3       8'h0C
`define SPALM_OFS_SP4       8'h10
`define SPALM_OFS_DB        8'h14
`define SPALM_OFS_DLY       8'h18
`define SPALM_OFS_STAT      8'h1C
`define SPALM_OFS_PEAK      8'h20
`define SPALM_OFS_VALLEY    8'h24
`define SPALM_OFS_CMD       8'h28
// ----------------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------------
`define SPALM_CTL_A1DIR     0
`define SPALM_CTL_A2DIR     1
`define SPALM_CTL_A1LAT     2
`define SPALM_CTL_A2LAT     3
`define SPALM_CTL_GRPDIS    4
`define SPALM_CTL_EXTEN     5
`define SPALM_CTL_PKLOCK    6
`define SPALM_CTL_VLLOCK    7
`define SPALM_CTL_FLSEL     8
`define SPALM_CTRL_RST      32'h0000_0000
`endif

// ### spalm_monitor.sv
`timescale 1ns/1ns
module spalm_monitor #(
    parameter int W = 24
) (
    input wire logic                core_clk,
    input wire logic                reset_n,
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic [1:0]          s_axi_bresp,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic [1:0]          s_axi_rresp,
    input wire logic                flash,
    input wire logic [2:0]          view_sel,
    input wire logic signed [W-1:0] display_value
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    chk_b_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
        else $error("write response not okay");
    chk_r_okay: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0)
        else $error("read response not okay");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    chk_wr_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
        |-> ##[1:2] s_axi_rvalid) else $error("read answer late");
    chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while pending");
    // ------------------------------------------------------------
    // Extreme view
    // ------------------------------------------------------------
    // Three cycles of view so a registered flash has landed
    chk_view_flash: assert property ((view_sel != 3'h0) [*3] |-> flash)
        else $error("extreme view not flashing");
    chk_peak_rise: assert property (view_sel == 3'h1 && $past(view_sel) == 3'h1
        |-> display_value >= $past(display_value)) else $error("peak fell");
    chk_valley_fall: assert property (view_sel == 3'h2 && $past(view_sel) == 3'h2
        |-> display_value <= $past(display_value)) else $error("valley rose");
endmodule
bind spalm_top spalm_monitor #(.W(W)) i_spalm_monitor (.core_clk(core_clk),
    .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .flash(flash), .view_sel(view_sel),
    .display_value(display_value));

// ### spalm_panel_model.sv
`timescale 1ns/1ns
module spalm_panel_model
    import spalm_pkg::*;
(
    input  wire logic            core_clk,
    output spalm_pkg::spalm_keys_t keys,
    output logic                 ext_reset_n
);
    logic [4:0] key_r = 5'h00;
    // Keys held well past the three-stage synchroniser
    assign keys = spalm_keys_t'(key_r);
    initial ext_reset_n = 1'b1;
    task automatic press(input int idx);
        key_r[idx] <= 1'b1;
        repeat (8) @(posedge core_clk);
        key_r[idx] <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
    task automatic ext_pulse();
        ext_reset_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        ext_reset_n <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask
endmodule

// ### spalm_pkg.sv
package spalm_pkg;
    typedef enum logic [3:0] {
        SPALM_RUN   = 4'b0001,
        SPALM_EXTR  = 4'b0010,
        SPALM_SETP  = 4'b0100,
        SPALM_MSG   = 4'b1000
    } spalm_mode_t;
    typedef struct packed {
        logic menu;
        logic reset;
        logic setpoint_view_button;
        logic incr;
        logic shift;
    } spalm_keys_t;
endpackage

// ### spalm_top.sv
`timescale 1ns/1ns
`include "spalm_map.svh"
module spalm_top
    import spalm_pkg::*;
#(
    parameter int          W          = 24,
    parameter int unsigned CYCLE_CLKS = `SPALM_CYCLE_CLKS
) (
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    input  wire logic                 sample,
    input  wire logic signed [W-1:0]  reading,
    input  wire spalm_pkg::spalm_keys_t keys,
    input  wire logic                 ext_reset_n,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    output logic [1:0]                s_axi_bresp,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    input  wire logic [7:0]           s_axi_araddr,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic [3:0]                sp_out,
    output logic                      flash,
    output logic [2:0]                view_sel,
    output logic signed [W-1:0]       display_value
);
    import spalm_pkg::*;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    localparam logic [31:0] CYC = CYCLE_CLKS;
    logic [31:0]       ctrl_r, ctrl_nxt, pend_r, pend_nxt;
    logic signed [W-1:0] lvl_r [4], lvl_nxt [4];
    logic signed [W-1:0] sdb_r, sdb_nxt, adb_r, adb_nxt;
    logic [13:0]       dly_r, dly_nxt;
    logic signed [W-1:0] peak_r, peak_nxt, vall_r, vall_nxt;
    logic              seed_r, seed_nxt;
    spalm_mode_t       mode_r, mode_nxt;
    logic [1:0]        spi_r, spi_nxt;
    logic [2:0]        dig_r, dig_nxt;
    logic signed [W-1:0] edit_r, edit_nxt;
    logic [31:0]       tmr_r, tmr_nxt;
    logic              awp_r, awp_nxt, wp_r, wp_nxt, bv_r, bv_nxt;
    logic              rv_r, rv_nxt;
    logic [7:0]        awa_r, awa_nxt;
    logic [31:0]       wd_r, wd_nxt, rd_r, rd_nxt;
    logic [4:0]        kq_r, kp_r;
    logic [2:0]        ext_sync_r;
    logic [3:0]        out_r, out_nxt;
    logic              fl_r, fl_nxt;
    logic [2:0]        vs_r, vs_nxt;
    logic signed [W-1:0] dv_r, dv_nxt;
    logic              ext_clr_r, ext_nxt;
    logic              cmd_clr, key_clr, a1, a2;
    logic [4:0]        kedge;

    assign s_axi_awready = !awp_r;
    assign s_axi_wready  = !wp_r;
    assign s_axi_bvalid  = bv_r;
    assign s_axi_bresp   = 2'b00;
    assign s_axi_arready = !rv_r;
    assign s_axi_rvalid  = rv_r;
    assign s_axi_rdata   = rd_r;
    assign s_axi_rresp   = 2'b00;
    assign sp_out        = out_r;
    assign flash         = fl_r;
    assign view_sel      = vs_r;
    assign display_value = dv_r;

    // ------------------------------------------------------------------------
    // Pin synchronisers; agreement of stages two and three counts
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            kq_r       <= 5'h00;
            kp_r       <= 5'h00;
            ext_sync_r <= 3'h7;
        end else begin
            kq_r       <= keys;
            kp_r       <= kq_r;
            ext_sync_r <= {ext_sync_r[1:0], ext_reset_n};
        end
    end
    // Key press pulses from the settled stages
    logic [4:0] k3_r, kst_r;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            k3_r  <= 5'h00;
            kst_r <= 5'h00;
        end else begin
            k3_r  <= kp_r;
            kst_r <= (kp_r == k3_r) ? kp_r : kst_r;
        end
    end
    assign kedge = (kp_r == k3_r) ? (kp_r & ~kst_r) : 5'h00;
    // keys fields: menu[4] reset[3] setpoint_view_button[2] incr[1] shift[0]

    // ------------------------------------------------------------------------
    // Alarm clear sources; external line only when enabled
    // ------------------------------------------------------------------------
    always_comb begin
        ext_nxt = ctrl_r[`SPALM_CTL_EXTEN] &&
                  !ext_sync_r[1] && !ext_sync_r[2];
    end
    assign key_clr = kedge[3] && mode_r == SPALM_RUN;
    assign cmd_clr = wp_r && awp_r && !bv_r &&
                     awa_r == `SPALM_OFS_CMD && wd_r[0];

    spalm_alarm #(.W(W)) u_al1 (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .sample      (sample),
        .reading     (reading),
        .level       (lvl_r[2]),
        .deadband    (adb_r),
        .delay       (dly_r[6:0]),
        .below       (ctrl_r[`SPALM_CTL_A1DIR]),
        .latch_en    (ctrl_r[`SPALM_CTL_A1LAT]),
        .disable_all (ctrl_r[`SPALM_CTL_GRPDIS]),
        .clear       (key_clr || ext_clr_r || cmd_clr),
        .active      (a1)
    );
    spalm_alarm #(.W(W)) u_al2 (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .sample      (sample),
        .reading     (reading),
        .level       (lvl_r[3]),
        .deadband    (adb_r),
        .delay       (dly_r[13:7]),
        .below       (ctrl_r[`SPALM_CTL_A2DIR]),
        .latch_en    (ctrl_r[`SPALM_CTL_A2LAT]),
        .disable_all (ctrl_r[`SPALM_CTL_GRPDIS]),
        .clear       (key_clr || ext_clr_r || cmd_clr),
        .active      (a2)
    );

    // ------------------------------------------------------------------------
    // Main setpoints, peak/valley, outputs
    // ------------------------------------------------------------------------
    always_comb begin
        logic signed [W-1:0] half;
        half     = sdb_r >>> 1;
        out_nxt  = {a2, a1, out_r[1:0]};
        for (int i = 0; i < 2; i++) begin
            if (sample) begin
                if (reading > lvl_r[i] + half) begin
                    out_nxt[i] = 1'b1;
                end else if (reading < lvl_r[i] - half) begin
                    out_nxt[i] = 1'b0;
                end
            end
        end
        if (ctrl_r[`SPALM_CTL_GRPDIS]) begin
            out_nxt[3:2] = 2'b00;
        end
        peak_nxt = peak_r;
        vall_nxt = vall_r;
        seed_nxt = seed_r;
        if (sample) begin
            if (seed_r) begin
                peak_nxt = reading;
                vall_nxt = reading;
                seed_nxt = 1'b0;
            end else begin
                if (reading > peak_r) peak_nxt = reading;
                if (reading < vall_r) vall_nxt = reading;
            end
        end
        if (mode_r == SPALM_EXTR && kedge[3]) begin
            seed_nxt = 1'b1;
        end
        // Flash select decode, extremes view always flashes
        unique case (ctrl_r[`SPALM_CTL_FLSEL +: 3])
            3'h0:    fl_nxt = 1'b0;
            3'h1:    fl_nxt = out_r[0];
            3'h2:    fl_nxt = out_r[1];
            3'h3:    fl_nxt = out_r[2];
            3'h4:    fl_nxt = out_r[3];
            3'h5:    fl_nxt = |out_r;
            default: fl_nxt = 1'b0;
        endcase
        if (mode_r == SPALM_EXTR || mode_r == SPALM_SETP) begin
            fl_nxt = 1'b1;
        end
        dv_nxt = (mode_r == SPALM_EXTR && vs_r == 3'h2) ? vall_r
               : (mode_r == SPALM_EXTR) ? peak_r
               : (mode_r == SPALM_SETP) ? edit_r : reading;
        // View code drops back to zero whenever the view is left
        vs_nxt = vs_r;
        if (mode_nxt != SPALM_EXTR) begin
            vs_nxt = 3'h0;
        end else if (mode_r == SPALM_RUN) begin
            vs_nxt = (kedge[1] && !ctrl_r[`SPALM_CTL_PKLOCK]) ? 3'h1 : 3'h2;
        end
    end

    // ------------------------------------------------------------------------
    // Front-panel modes
    // ------------------------------------------------------------------------
    always_comb begin
        mode_nxt = mode_r;
        spi_nxt  = spi_r;
        dig_nxt  = dig_r;
        edit_nxt = edit_r;
        tmr_nxt  = (tmr_r != 32'h0) ? tmr_r - 32'h1 : 32'h0;
        for (int i = 0; i < 4; i++) lvl_nxt[i] = lvl_r[i];
        unique case (mode_r)
            SPALM_RUN: begin
                if (kedge[1] && !ctrl_r[`SPALM_CTL_PKLOCK]) begin
                    mode_nxt = SPALM_EXTR;
                end else if (kedge[0] && !ctrl_r[`SPALM_CTL_VLLOCK]) begin
                    mode_nxt = SPALM_EXTR;
                end else if (kedge[2]) begin
                    mode_nxt = SPALM_SETP;
                    spi_nxt  = 2'h0;
                    dig_nxt  = 3'h0;
                    edit_nxt = lvl_r[0];
                    tmr_nxt  = CYC;
                end
            end
            SPALM_EXTR: begin
                if (kedge[2] || kedge[4] || kedge[3]) begin
                    mode_nxt = SPALM_RUN;
                end
            end
            SPALM_SETP: begin
                if (kedge[0]) begin
                    dig_nxt = (dig_r == 3'h5) ? 3'h0 : dig_r + 3'h1;
                    tmr_nxt = CYC;
                end else if (kedge[1]) begin
                    edit_nxt = edit_r + W'(1 << (4 * dig_r));
                    tmr_nxt  = CYC;
                end else if (kedge[3]) begin
                    mode_nxt = SPALM_RUN;
                end else if (kedge[2] || tmr_r == 32'h1) begin
                    // Timeout steps on without storing the edit
                    if (kedge[2]) lvl_nxt[spi_r] = edit_r;
                    spi_nxt  = spi_r + 2'h1;
                    edit_nxt = lvl_r[spi_r + 2'h1];
                    dig_nxt  = 3'h0;
                    tmr_nxt  = CYC;
                    if (spi_r == 2'h3) mode_nxt = SPALM_RUN;
                end
            end
            SPALM_MSG: begin
                if (tmr_r == 32'h1) mode_nxt = SPALM_RUN;
            end
            default: mode_nxt = SPALM_RUN;
        endcase
        if (kedge[4] && mode_r == SPALM_RUN) begin
            mode_nxt = SPALM_MSG;
            tmr_nxt  = 32'(`SPALM_MSG_CLKS);
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite slave; pending config commits on a menu press in run mode
    // ------------------------------------------------------------------------
    always_comb begin
        awp_nxt  = awp_r || s_axi_awvalid;
        wp_nxt   = wp_r || s_axi_wvalid;
        awa_nxt  = (!awp_r && s_axi_awvalid) ? s_axi_awaddr : awa_r;
        wd_nxt   = (!wp_r && s_axi_wvalid) ? s_axi_wdata : wd_r;
        bv_nxt   = bv_r && !s_axi_bready;
        ctrl_nxt = ctrl_r;
        pend_nxt = pend_r;
        sdb_nxt  = sdb_r;
        adb_nxt  = adb_r;
        dly_nxt  = dly_r;
        if (awp_r && wp_r && !bv_r) begin
            bv_nxt  = 1'b1;
            awp_nxt = 1'b0;
            wp_nxt  = 1'b0;
            unique case (awa_r)
                `SPALM_OFS_CTRL: pend_nxt = wd_r;
                `SPALM_OFS_DB:   sdb_nxt  = W'(wd_r[15:0]);
                `SPALM_OFS_DLY:  dly_nxt  = wd_r[13:0];
                `SPALM_OFS_STAT: adb_nxt  = W'(wd_r[15:0]);
                default: ;
            endcase
        end
        if (kedge[4] && mode_r == SPALM_RUN) begin
            ctrl_nxt = pend_r;
        end
        rv_nxt = rv_r ? !s_axi_rready : s_axi_arvalid;
        rd_nxt = rd_r;
        if (!rv_r && s_axi_arvalid) begin
            unique case (s_axi_araddr)
                `SPALM_OFS_CTRL:   rd_nxt = pend_r;
                `SPALM_OFS_SP1:    rd_nxt = 32'(lvl_r[0]);
                `SPALM_OFS_SP2:    rd_nxt = 32'(lvl_r[1]);
                `SPALM_OFS_SP3:    rd_nxt = 32'(lvl_r[2]);
                `SPALM_OFS_SP4:    rd_nxt = 32'(lvl_r[3]);
                `SPALM_OFS_DLY:    rd_nxt = 32'(dly_r);
                `SPALM_OFS_STAT:   rd_nxt = {24'h0, mode_r, out_r};
                `SPALM_OFS_PEAK:   rd_nxt = 32'(peak_r);
                `SPALM_OFS_VALLEY: rd_nxt = 32'(vall_r);
                default:           rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Registers only
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= `SPALM_CTRL_RST;
            pend_r <= `SPALM_CTRL_RST;
            for (int i = 0; i < 4; i++) lvl_r[i] <= '0;
            {sdb_r, adb_r, peak_r, vall_r, edit_r} <= '0;
            dly_r <= 14'h0000;
            seed_r <= 1'b1;
            mode_r <= SPALM_RUN;
            {spi_r, dig_r, tmr_r} <= '0;
            {awp_r, wp_r, bv_r, rv_r, awa_r, wd_r, rd_r} <= '0;
            {out_r, fl_r, vs_r, dv_r, ext_clr_r} <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            pend_r <= pend_nxt;
            for (int i = 0; i < 4; i++) lvl_r[i] <= lvl_nxt[i];
            sdb_r <= sdb_nxt;
            adb_r <= adb_nxt;
            peak_r <= peak_nxt;
            vall_r <= vall_nxt;
            edit_r <= edit_nxt;
            dly_r <= dly_nxt;
            seed_r <= seed_nxt;
            mode_r <= mode_nxt;
            spi_r <= spi_nxt;
            dig_r <= dig_nxt;
            tmr_r <= tmr_nxt;
            awp_r <= awp_nxt;
            wp_r <= wp_nxt;
            bv_r <= bv_nxt;
            rv_r <= rv_nxt;
            awa_r <= awa_nxt;
            wd_r <= wd_nxt;
            rd_r <= rd_nxt;
            out_r <= out_nxt;
            fl_r <= fl_nxt;
            vs_r <= vs_nxt;
            dv_r <= dv_nxt;
            ext_clr_r <= ext_nxt;
        end
    end
endmodule

// ### tb_spalm_top.sv
`timescale 1ns/1ns
module tb_spalm_top;
    import spalm_pkg::*;
    localparam int K_SHIFT = 0, K_INCR = 1, K_SETP = 2, K_RST = 3, K_MENU = 4;
    logic core_clk = 1'b0, reset_n = 1'b0, sample = 1'b0;
    logic signed [23:0] reading = 24'h000000;
    logic signed [23:0] disp;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic awready, wready, bvalid, arready, rvalid, flash, ext_n;
    logic [1:0] bresp, rresp;
    logic [3:0] sp_out;
    logic [2:0] view_sel;
    spalm_keys_t keys;
    int n_fail = 0, n_checks = 0, cyc = 0;
    always #4 core_clk = ~core_clk;
    spalm_panel_model i_spalm_panel_model (.core_clk(core_clk), .keys(keys),
        .ext_reset_n(ext_n));
    spalm_top #(.W(24), .CYCLE_CLKS(200)) i_spalm_top (.core_clk(core_clk),
        .reset_n(reset_n), .sample(sample), .reading(reading), .keys(keys),
        .ext_reset_n(ext_n), .s_axi_awvalid(awv), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wv), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .sp_out(sp_out), .flash(flash), .view_sel(view_sel),
        .display_value(disp));
    // Hang guard, far above the expected run length
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Both channels offered together, each released once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awv <= 1'b1; wv <= 1'b1; awaddr <= a; wdata <= d; bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awv && awready) awv <= 1'b0;
            if (wv && wready) wv <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic axr(input logic [7:0] a);
        arv <= 1'b1; araddr <= a; rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arv && arready) arv <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        rready <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic smp(input logic signed [23:0] r);
        sample <= 1'b1; reading <= r;
        @(posedge core_clk);
        sample <= 1'b0;
        repeat (5) @(posedge core_clk);
    endtask
    // Menu in run commits control, then the restart message runs out
    task automatic commit(input logic [31:0] c);
        axw(8'h00, c);
        i_spalm_panel_model.press(K_MENU);
        repeat (1100) @(posedge core_clk);
    endtask
    task automatic t_peak();
        smp(24'sd5); smp(24'sd9); smp(-24'sd3); smp(24'sd7);
        axr(8'h20); chk(32'(v[23:0]), 32'h0000_0009);
        axr(8'h24); chk(32'(v[23:0]), 32'h00FF_FFFD);
        i_spalm_panel_model.press(K_INCR);
        chk(32'(view_sel), 32'h1); chk(32'(disp[23:0]), 32'h9);
        chk(32'(flash), 32'h1);
        smp(24'sd12); chk(32'(disp[23:0]), 32'hC);
        i_spalm_panel_model.press(K_MENU); chk(32'(view_sel), 32'h0);
        axr(8'h20); chk(32'(v[23:0]), 32'hC);
        i_spalm_panel_model.press(K_SHIFT);
        chk(32'(view_sel), 32'h2); chk(32'(disp[23:0]), 32'hFF_FFFD);
        i_spalm_panel_model.press(K_RST); chk(32'(view_sel), 32'h0);
        smp(24'sd4);
        axr(8'h20); chk(32'(v[23:0]), 32'h4);
        axr(8'h24); chk(32'(v[23:0]), 32'h4);
    endtask
    task automatic t_delay();
        axw(8'h1C, 32'h0); axw(8'h18, 32'h0000_0002);
        smp(-24'sd1); smp(24'sd5); chk(32'(sp_out[3]), 32'h1);
        chk(32'(sp_out[2]), 32'h0);
        smp(24'sd5); smp(-24'sd1); smp(24'sd5);
        chk(32'(sp_out[2]), 32'h0);
        smp(24'sd5); smp(24'sd5); chk(32'(sp_out[2]), 32'h1);
        axw(8'h1C, 32'h3);
        smp(-24'sd2); chk(32'(sp_out[2]), 32'h1);
        smp(-24'sd4); chk(32'(sp_out[2]), 32'h0);
    endtask
    task automatic t_ctrl();
        commit(32'h0000_0328);
        smp(24'sd5); smp(24'sd5); smp(24'sd5);
        chk(32'(sp_out[2]), 32'h1); chk(32'(flash), 32'h1);
        smp(-24'sd4); chk(32'(flash), 32'h0);
        chk(32'(sp_out[3]), 32'h1);
        i_spalm_panel_model.ext_pulse(); chk(32'(sp_out[3]), 32'h0);
        smp(24'sd5);
        chk(32'(sp_out[3]), 32'h1);
        axw(8'h28, 32'h1);
        chk(32'(sp_out[3]), 32'h0);
        smp(24'sd5);
        i_spalm_panel_model.press(K_RST);
        chk(32'(sp_out[3]), 32'h0);
        commit(32'h0000_0510);
        smp(24'sd5); smp(24'sd5); smp(24'sd5);
        chk(32'(sp_out[3:2]), 32'h0); chk(32'(flash), 32'h1);
    endtask
    task automatic t_setp();
        i_spalm_panel_model.press(K_SETP);
        i_spalm_panel_model.press(K_INCR);
        chk(32'(disp[23:0]), 32'h1);
        i_spalm_panel_model.press(K_SETP);
        axr(8'h04);
        chk(v, 32'h1);
        i_spalm_panel_model.press(K_INCR);
        i_spalm_panel_model.press(K_RST);
        axr(8'h08);
        chk(v, 32'h0);
        i_spalm_panel_model.press(K_SETP);
        repeat (700) @(posedge core_clk);
        axr(8'h1C);
        chk(32'(v[7:4]), 32'h4);
        repeat (200) @(posedge core_clk);
        axr(8'h1C);
        chk(32'(v[7:4]), 32'h1);
        axw(8'h14, 32'h4);
        smp(-24'sd2);
        chk(32'(sp_out[0]), 32'h0);
        smp(24'sd2);
        chk(32'(sp_out[0]), 32'h0);
        smp(24'sd4);
        chk(32'(sp_out[0]), 32'h1);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        t_peak();
        t_delay();
        t_ctrl();
        t_setp();
        report_and_stop();
    end
endmodule
